// ===== hw/tsg_top.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`include "tsg_defines.svh"

// How it works
// RULE1: The 24-bit configuration word is read and written at index 0x2a.
// RULE2: Each sample feeds interpolation field plus one output bits.
// RULE3: Rate code 111 gives 16.384 MHz, each step down to 001 halves, 000 gives 32 kHz.
// RULE4: One output bit lasts eight internal clock periods.
// RULE5: The output clock lags by the phase field in eighths of a bit.
// RULE6: The data output lags by the number of whole bits in its field.
// RULE7: With the loopback bit set the stream is returned internally.
// RULE8: Stream and clock are produced only while the run bit is set.
// RULE9: Bits 15 and 11 are stored but steer nothing.
// RULE10: Dedicated clock and data outputs drive the external test converter.
// RULE11: All generator timing is derived from the master clock input.
// RULE12: With run clear both outputs stay low and all state restarts; loop_d_ff keeps its last value.
// RULE13: After reset every configuration field is zero.
module tsg_top import tsg_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        mclk_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [23:0] sample_data,
  output      logic        sample_take,
  output      logic        test_dac_clock_out,
  output      logic        test_dac_data_out,
  output      logic        loop_data,
  output      logic        loop_valid
);

  function automatic logic [10:0] tsg_divisor(input logic [2:0] code);
    if (code == 3'h0) begin
      return 11'(`TSG_MCLK_KHZ / `TSG_RATE_LOW_KHZ); // [RULE11]
    end
    return 11'((`TSG_MCLK_KHZ / `TSG_RATE_TOP_KHZ)
               << (`TSG_RATE_TOP_CODE - code));
  endfunction

  // Bus clock domain: registers and the configuration handover.
  tsg_cfg_t    cfg_ff,      nxt_cfg;
  tsg_cfg_t    shadow_ff,   nxt_shadow;
  logic        req_tgl_ff,  nxt_req_tgl;
  logic        dirty_ff,    nxt_dirty;
  logic        aw_held_ff,  nxt_aw_held;
  logic        w_held_ff,   nxt_w_held;
  logic [7:0]  aw_addr_ff,  nxt_aw_addr;
  logic [31:0] w_data_ff,   nxt_w_data;
  logic [3:0]  w_strb_ff,   nxt_w_strb;
  logic        awready_ff,  nxt_awready;
  logic        wready_ff,   nxt_wready;
  logic        bvalid_ff,   nxt_bvalid;
  logic [1:0]  bresp_ff,    nxt_bresp;
  logic        arready_ff,  nxt_arready;
  logic        rvalid_ff,   nxt_rvalid;
  logic [31:0] rdata_ff,    nxt_rdata;
  logic [1:0]  rresp_ff,    nxt_rresp;
  logic        ack_s1_ff, ack_s2_ff, ack_s3_ff, ack_seen_ff;
  logic        run_s1_ff, run_s2_ff, run_s3_ff, run_seen_ff;
  logic        wr_go;
  logic [23:0] wmask;
  logic [23:0] stat_word;
  tsg_cfg_t    l_cfg_ff,    nxt_l_cfg;
  logic        ack_tgl_ff,  nxt_ack_tgl;

  always_ff @(posedge aclk) begin
    ack_s1_ff <= ack_tgl_ff;
    ack_s2_ff <= ack_s1_ff;
    ack_s3_ff <= ack_s2_ff;
    run_s1_ff <= l_cfg_ff.run;
    run_s2_ff <= run_s1_ff;
    run_s3_ff <= run_s2_ff;
    if (!aresetn) begin
      ack_seen_ff <= 1'b0;
      run_seen_ff <= 1'b0;
    end else begin
      if (ack_s2_ff == ack_s3_ff) begin
        ack_seen_ff <= ack_s3_ff;
      end
      if (run_s2_ff == run_s3_ff) begin
        run_seen_ff <= run_s3_ff;
      end
    end
  end

  always_comb begin
    wr_go       = aw_held_ff && w_held_ff && !bvalid_ff;
    wmask       = {{8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    stat_word   = '0;
    stat_word[`TSG_STAT_BUSY_BIT] = req_tgl_ff ^ ack_seen_ff;
    stat_word[`TSG_STAT_RUN_BIT]  = run_seen_ff;
    nxt_cfg     = cfg_ff;
    nxt_shadow  = shadow_ff;
    nxt_req_tgl = req_tgl_ff;
    nxt_dirty   = dirty_ff;
    nxt_aw_held = aw_held_ff || (s_axi_awvalid && awready_ff);
    nxt_w_held  = w_held_ff || (s_axi_wvalid && wready_ff);
    nxt_aw_addr = (s_axi_awvalid && awready_ff) ? s_axi_awaddr : aw_addr_ff;
    nxt_w_data  = (s_axi_wvalid && wready_ff) ? s_axi_wdata : w_data_ff;
    nxt_w_strb  = (s_axi_wvalid && wready_ff) ? s_axi_wstrb : w_strb_ff;
    nxt_bvalid  = bvalid_ff && !s_axi_bready;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff && !s_axi_rready;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (wr_go) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      if (aw_addr_ff == `TSG_CFG_ADDR) begin
        // Reserved bits are stored like the rest but steer nothing. [RULE9]
        nxt_cfg   = (cfg_ff & ~wmask) | (w_data_ff[23:0] & wmask); // [RULE1]
        nxt_dirty = 1'b1;
        nxt_bresp = `TSG_RESP_OKAY;
      end else if (aw_addr_ff == `TSG_STAT_ADDR) begin
        nxt_bresp = `TSG_RESP_OKAY;
      end else begin
        nxt_bresp = `TSG_RESP_SLVERR;
      end
    end
    // Hand the latest word over once the previous handover is acknowledged.
    if (dirty_ff && (req_tgl_ff == ack_seen_ff)) begin
      // Taking nxt_cfg keeps a write that lands in this cycle.
      nxt_shadow  = nxt_cfg;
      nxt_req_tgl = !req_tgl_ff;
      nxt_dirty   = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      if (s_axi_araddr == `TSG_CFG_ADDR) begin
        nxt_rdata = {8'h00, cfg_ff}; // [RULE1]
        nxt_rresp = `TSG_RESP_OKAY;
      end else if (s_axi_araddr == `TSG_STAT_ADDR) begin
        nxt_rdata = {8'h00, stat_word};
        nxt_rresp = `TSG_RESP_OKAY;
      end else begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `TSG_RESP_SLVERR;
      end
    end
    nxt_awready = !nxt_aw_held;
    nxt_wready  = !nxt_w_held;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff     <= `TSG_CFG_RESET; // [RULE13]
      shadow_ff  <= `TSG_CFG_RESET;
      req_tgl_ff <= 1'b0;
      dirty_ff   <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `TSG_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `TSG_RESP_OKAY;
    end else if (ce) begin
      cfg_ff     <= nxt_cfg;
      shadow_ff  <= nxt_shadow;
      req_tgl_ff <= nxt_req_tgl;
      dirty_ff   <= nxt_dirty;
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Master clock domain: the generator itself.
  logic           rst_s1_ff, rst_s2_ff, rst_s3_ff, lrst_n_ff;
  logic           ce_s1_ff, ce_s2_ff, ce_s3_ff, lce_ff;
  logic           rq_s1_ff, rq_s2_ff, rq_s3_ff;
  tsg_gen_state_t state_ff,    nxt_state;
  logic [10:0]    div_cnt_ff,  nxt_div_cnt;
  logic [2:0]     phase_ff,    nxt_phase;
  logic [7:0]     interp_cnt_ff, nxt_interp_cnt;
  logic [23:0]    sample_ff,   nxt_sample;
  logic [23:0]    acc_ff,      nxt_acc;
  logic [63:0]    hist_ff,     nxt_hist;
  logic           clk_out_ff,  nxt_clk_out;
  logic           data_out_ff, nxt_data_out;
  logic           take_ff,     nxt_take;
  logic           loop_d_ff,   nxt_loop_d;
  logic           loop_v_ff,   nxt_loop_v;
  logic           cfg_load;
  logic [23:0]    smp;
  logic [24:0]    sum;

  always_ff @(posedge mclk_in) begin
    rst_s1_ff <= aresetn;
    rst_s2_ff <= rst_s1_ff;
    rst_s3_ff <= rst_s2_ff;
    ce_s1_ff  <= ce;
    ce_s2_ff  <= ce_s1_ff;
    ce_s3_ff  <= ce_s2_ff;
    rq_s1_ff  <= req_tgl_ff;
    rq_s2_ff  <= rq_s1_ff;
    rq_s3_ff  <= rq_s2_ff;
    if (rst_s2_ff == rst_s3_ff) begin
      lrst_n_ff <= rst_s3_ff;
    end
    if (ce_s2_ff == ce_s3_ff) begin
      lce_ff <= ce_s3_ff;
    end
  end

  always_comb begin
    cfg_load       = (rq_s2_ff == rq_s3_ff) && (rq_s3_ff != ack_tgl_ff);
    nxt_l_cfg      = cfg_load ? shadow_ff : l_cfg_ff;
    nxt_ack_tgl    = cfg_load ? rq_s3_ff : ack_tgl_ff;
    nxt_state      = l_cfg_ff.run ? TSG_RUN : TSG_IDLE; // [RULE8]
    nxt_div_cnt    = div_cnt_ff;
    nxt_phase      = phase_ff;
    nxt_interp_cnt = interp_cnt_ff;
    nxt_sample     = sample_ff;
    nxt_acc        = acc_ff;
    nxt_hist       = hist_ff;
    nxt_data_out   = data_out_ff;
    nxt_take       = 1'b0;
    nxt_loop_d     = loop_d_ff;
    nxt_loop_v     = 1'b0;
    smp            = (interp_cnt_ff == 8'h00) ? sample_data : sample_ff;
    sum            = {1'b0, acc_ff} + {1'b0, smp ^ `TSG_SIGN_FLIP};
    case (nxt_state)
      TSG_IDLE: begin
        // Clear everything but loop_d_ff so the next run starts from the same point.
        nxt_div_cnt    = 11'h000; // [RULE12]
        nxt_phase      = 3'h0;
        nxt_interp_cnt = 8'h00;
        nxt_sample     = 24'h000000;
        nxt_acc        = 24'h000000;
        nxt_hist       = 64'h0;
        nxt_data_out   = 1'b0;
      end
      TSG_RUN: begin
        if (div_cnt_ff == 11'h000) begin
          nxt_div_cnt = tsg_divisor(l_cfg_ff.rate) - 11'h001; // [RULE3]
          nxt_phase   = phase_ff + 3'h1;
          if (phase_ff == `TSG_PHASES_PER_BIT) begin
            nxt_acc  = sum[23:0]; // [RULE4]
            nxt_hist = {hist_ff[62:0], sum[24]};
            nxt_data_out = nxt_hist[l_cfg_ff.data_bit_delay]; // [RULE6]
            nxt_loop_d   = nxt_hist[l_cfg_ff.data_bit_delay];
            nxt_loop_v   = l_cfg_ff.loopback; // [RULE7]
            if (interp_cnt_ff == 8'h00) begin
              nxt_sample     = sample_data; // [RULE2]
              nxt_take       = 1'b1;
              nxt_interp_cnt = l_cfg_ff.interpolation_factor;
            end else begin
              nxt_interp_cnt = interp_cnt_ff - 8'h01;
            end
          end
        end else begin
          nxt_div_cnt = div_cnt_ff - 11'h001;
        end
      end
      default: begin
        nxt_div_cnt = 11'h000;
      end
    endcase
    // The clock goes high half a bit after the delayed phase origin.
    nxt_clk_out = (nxt_state == TSG_RUN) &&
                  (3'(nxt_phase - l_cfg_ff.clock_phase_delay)
                   >= `TSG_CLK_HIGH_PHASE); // [RULE5]
  end

  always_ff @(posedge mclk_in) begin
    if (!lrst_n_ff) begin
      l_cfg_ff      <= `TSG_CFG_RESET; // [RULE13]
      ack_tgl_ff    <= 1'b0;
      state_ff      <= TSG_IDLE;
      div_cnt_ff    <= 11'h000;
      phase_ff      <= 3'h0;
      interp_cnt_ff <= 8'h00;
      sample_ff     <= 24'h000000;
      acc_ff        <= 24'h000000;
      hist_ff       <= 64'h0;
      clk_out_ff    <= 1'b0;
      data_out_ff   <= 1'b0;
      take_ff       <= 1'b0;
      loop_d_ff     <= 1'b0;
      loop_v_ff     <= 1'b0;
    end else if (lce_ff) begin
      l_cfg_ff      <= nxt_l_cfg;
      ack_tgl_ff    <= nxt_ack_tgl;
      state_ff      <= nxt_state;
      div_cnt_ff    <= nxt_div_cnt;
      phase_ff      <= nxt_phase;
      interp_cnt_ff <= nxt_interp_cnt;
      sample_ff     <= nxt_sample;
      acc_ff        <= nxt_acc;
      hist_ff       <= nxt_hist;
      clk_out_ff    <= nxt_clk_out;
      data_out_ff   <= nxt_data_out;
      take_ff       <= nxt_take;
      loop_d_ff     <= nxt_loop_d;
      loop_v_ff     <= nxt_loop_v;
    end
  end

  assign test_dac_clock_out = clk_out_ff; // [RULE10]
  assign test_dac_data_out  = data_out_ff; // [RULE10]
  assign sample_take        = take_ff;
  assign loop_data          = loop_d_ff;
  assign loop_valid         = loop_v_ff;

  // Properties of both clock domains.
  property p_cfg_write;
    @(posedge aclk) disable iff (!aresetn || !ce)
    wr_go && (aw_addr_ff == `TSG_CFG_ADDR) && (w_strb_ff == 4'hf)
      |=> cfg_ff == $past(w_data_ff[23:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) // [RULE1]
    else $error("configuration word not stored on write");

  property p_reset_zero;
    @(posedge aclk) $past(!aresetn) |-> cfg_ff == `TSG_CFG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // [RULE13]
    else $error("configuration not zero after reset");

  property p_idle_low;
    @(posedge mclk_in) disable iff (!lrst_n_ff || !lce_ff)
    !l_cfg_ff.run |=> !clk_out_ff && !data_out_ff && !take_ff;
  endproperty
  a_idle_low: assert property (p_idle_low) // [RULE12]
    else $error("outputs active while stopped");

  property p_div_reload;
    @(posedge mclk_in) disable iff (!lrst_n_ff || !lce_ff)
    l_cfg_ff.run && (div_cnt_ff == 11'h000)
      |=> div_cnt_ff == tsg_divisor($past(l_cfg_ff.rate)) - 11'h001;
  endproperty
  a_div_reload: assert property (p_div_reload) // [RULE3]
    else $error("internal clock divider reloaded wrongly");

  property p_bit_edge;
    @(posedge mclk_in) disable iff (!lrst_n_ff || !lce_ff)
    $past(l_cfg_ff.run) && l_cfg_ff.run && $changed(hist_ff)
      |-> $past(phase_ff) == `TSG_PHASES_PER_BIT
          && $past(div_cnt_ff) == 11'h000;
  endproperty
  a_bit_edge: assert property (p_bit_edge) // [RULE4]
    else $error("bit boundary not at eighth internal clock");

  property p_clk_phase;
    @(posedge mclk_in) disable iff (!lrst_n_ff || !lce_ff)
    $past(l_cfg_ff.run) && $stable(l_cfg_ff)
      |-> clk_out_ff == (3'(phase_ff - l_cfg_ff.clock_phase_delay)
                         >= `TSG_CLK_HIGH_PHASE);
  endproperty
  a_clk_phase: assert property (p_clk_phase) // [RULE5]
    else $error("output clock phase does not match delay");

  property p_data_delay;
    @(posedge mclk_in) disable iff (!lrst_n_ff || !lce_ff)
    l_cfg_ff.run && $changed(hist_ff) && $stable(l_cfg_ff)
      |-> data_out_ff == hist_ff[l_cfg_ff.data_bit_delay];
  endproperty
  a_data_delay: assert property (p_data_delay) // [RULE6]
    else $error("data output not taken from delayed bit");

  property p_interp;
    @(posedge mclk_in) disable iff (!lrst_n_ff || !lce_ff)
    take_ff && $stable(l_cfg_ff)
      |-> interp_cnt_ff == l_cfg_ff.interpolation_factor;
  endproperty
  a_interp: assert property (p_interp) // [RULE2]
    else $error("interpolation count not loaded on sample take");

  property p_loop;
    @(posedge mclk_in) disable iff (!lrst_n_ff || !lce_ff)
    loop_v_ff |-> loop_d_ff == data_out_ff && $past(l_cfg_ff.loopback);
  endproperty
  a_loop: assert property (p_loop) // [RULE7]
    else $error("loopback bit differs from output bit");

  c_run_start: cover property (@(posedge mclk_in)
    state_ff == TSG_IDLE && l_cfg_ff.run);
  c_clk_rise: cover property (@(posedge mclk_in)
    $rose(clk_out_ff) && l_cfg_ff.clock_phase_delay == 3'h7);
  c_take: cover property (@(posedge mclk_in) take_ff);
  c_loop: cover property (@(posedge mclk_in) loop_v_ff);

endmodule // tsg_top

// ===== pkg/tsg_defines.svh
`ifndef TSG_DEFINES_SVH
`define TSG_DEFINES_SVH

// Register map: printed offsets are word indices, byte address is four times.
`define TSG_CFG_INDEX       8'h2a
`define TSG_STAT_INDEX      8'h30
`define TSG_CFG_ADDR        (8'(`TSG_CFG_INDEX * 4))
`define TSG_STAT_ADDR       (8'(`TSG_STAT_INDEX * 4))
`define TSG_CFG_RESET       24'h000000
`define TSG_STAT_BUSY_BIT   0
`define TSG_STAT_RUN_BIT    1

// Bus responses.
`define TSG_RESP_OKAY       2'b00
`define TSG_RESP_SLVERR     2'b10

// Generator clocking; frequencies in kHz.
`define TSG_MCLK_KHZ        32768
`define TSG_RATE_TOP_KHZ    16384
`define TSG_RATE_LOW_KHZ    32
`define TSG_RATE_TOP_CODE   3'h7
`define TSG_PHASES_PER_BIT  3'h7
`define TSG_CLK_HIGH_PHASE  3'h4

// Offset-binary conversion of the signed sample.
`define TSG_SIGN_FLIP       24'h800000

`endif

// ===== pkg/tsg_pkg.sv
package tsg_pkg;

  // Layout of the generator configuration word.
  typedef struct packed {
    logic [7:0] interpolation_factor;
    logic       rsvd15;
    logic [2:0] rate;
    logic       rsvd11;
    logic [2:0] clock_phase_delay;
    logic       loopback;
    logic       run;
    logic [5:0] data_bit_delay;
  } tsg_cfg_t;

  typedef enum logic {TSG_IDLE, TSG_RUN} tsg_gen_state_t;

endpackage

// ===== verification/tsg_dac_model.sv
`timescale 1ns/100ps

// Stands in for the external test converter. It samples the data line on
// each rising edge of the test clock and keeps counts for the bench to read.
module tsg_dac_model (
  input wire logic mclk_in,
  input wire logic clk_in,
  input wire logic data_in,
  input wire logic take,
  input wire logic loop_data,
  input wire logic loop_valid
);
  int   cyc = 0;
  int   n_take = 0;
  int   t_take = 0;
  int   per_take = 0;
  int   r_since = 0;
  int   n_lv = 0;
  int   n_ldiff = 0;
  int   n_high = 0;
  int   rt[$];
  int   off_q[$];
  logic bits[$];
  logic clk_d = 1'b0;

  always @(posedge mclk_in) begin
    cyc++;
    if (clk_in || data_in) n_high++;
    if (loop_valid) n_lv++;
    if (take) begin
      n_take++;
      t_take = cyc;
      per_take = r_since;
      r_since = 0;
    end
    if (clk_in && !clk_d) begin
      bits.push_back(data_in);
      rt.push_back(cyc);
      off_q.push_back(cyc - t_take);
      r_since++;
      if (loop_data !== data_in) n_ldiff++;
    end
    clk_d = clk_in;
  end
endmodule // tsg_dac_model

// ===== verification/tb.sv
`timescale 1ns/100ps
`include "tsg_defines.svh"

module tb import tsg_pkg::*; ;
  localparam int LIMIT = 90000;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic        mclk_in = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [23:0] sample_data = 24'h400000;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        sample_take, test_dac_clock_out, test_dac_data_out;
  logic        loop_data, loop_valid;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;

  tsg_top dut (
    .aclk, .aresetn, .ce, .mclk_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_data,
    .sample_take, .test_dac_clock_out, .test_dac_data_out,
    .loop_data, .loop_valid
  );

  tsg_dac_model dac (
    .mclk_in, .clk_in(test_dac_clock_out), .data_in(test_dac_data_out),
    .take(sample_take), .loop_data, .loop_valid
  );

  always #20 aclk = ~aclk;

  // The link clock starts off phase so its edges never meet the bus clock.
  initial begin
    #7;
    forever #16 mclk_in = ~mclk_in;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      $display("wrong value cycles expected below %0d seen %0d", LIMIT,
               cycles);
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("write resp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  function automatic logic [31:0] cfg(logic [7:0] ip, logic [2:0] rt,
      logic [2:0] cd, logic lp, logic dd_run, logic [5:0] dd);
    tsg_cfg_t c;
    c = '{ip, 1'b0, rt, 1'b0, cd, lp, dd_run, dd};
    return {8'h00, c};
  endfunction

  task automatic settle(input logic run);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      rd(`TSG_STAT_ADDR, d, r);
      n++;
    end while (d[1:0] !== {run, 1'b0} && n < 100);
    chk("status", {30'h0, run, 1'b0}, d);
  endtask

  // Stops the generator first so every run starts from a clean state.
  task automatic start(input logic [31:0] c, output int b);
    wr(`TSG_CFG_ADDR, c & ~32'h40, 4'hf, `TSG_RESP_OKAY);
    settle(1'b0);
    b = dac.bits.size();
    wr(`TSG_CFG_ADDR, c, 4'hf, `TSG_RESP_OKAY);
    settle(1'b1);
  endtask

  task automatic rises(input int n);
    int b;
    b = dac.rt.size();
    while (dac.rt.size() < b + n) @(negedge mclk_in);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    int          h;
    logic [1:0]  o;
    rd(`TSG_CFG_ADDR, d, r);
    chk("config after reset", 32'h0, d);
    chk("read resp", 32'(`TSG_RESP_OKAY), 32'(r));
    o = {test_dac_clock_out, test_dac_data_out};
    chk("outputs after reset", 32'h0, 32'(o));
    rd(8'h10, d, r);
    chk("unmapped read", 32'(`TSG_RESP_SLVERR), 32'(r));
    wr(8'h10, 32'hffffffff, 4'hf, `TSG_RESP_SLVERR);
    wr(`TSG_CFG_ADDR, 32'hffffffff, 4'hf, `TSG_RESP_OKAY);
    rd(`TSG_CFG_ADDR, d, r);
    chk("config ones", 32'h00ffffff, d);
    wr(`TSG_CFG_ADDR, 32'h0, 4'h1, `TSG_RESP_OKAY);
    rd(`TSG_CFG_ADDR, d, r);
    chk("config strobe", 32'h00ffff00, d);
    wr(`TSG_CFG_ADDR, 32'h0, 4'hf, `TSG_RESP_OKAY);
    settle(1'b0);
    h = dac.n_high;
    repeat (300) @(negedge mclk_in);
    chk("stopped outputs", 32'h0, dac.n_high - h);
    $display("register test done");
  endtask

  task automatic t_rates;
    int b;
    int p;
    int e;
    for (int k = 0; k < 8; k++) begin
      start(cfg(8'h00, 3'(k), 3'h0, 1'b0, 1'b1, 6'h00) | 32'h8800, b);
      rises(3);
      p = dac.rt[dac.rt.size() - 1] - dac.rt[dac.rt.size() - 2];
      e = (k == 0) ? 8192 : 8 << (8 - k);
      chk("bit period", e, p);
    end
    $display("rate test done");
  endtask

  task automatic t_phase;
    int b;
    int o;
    int base;
    base = 0;
    for (int c = 0; c < 8; c++) begin
      start(cfg(8'h00, 3'h7, 3'(c), 1'b0, 1'b1, 6'h00), b);
      rises(4);
      o = dac.off_q[dac.off_q.size() - 1] % 16;
      if (c == 0) base = o;
      chk("clock phase", (base + 2 * c) % 16, o);
    end
    $display("phase test done");
  endtask

  task automatic t_interp;
    int ips[3];
    int b;
    int t;
    ips = '{0, 3, 255};
    for (int i = 0; i < 3; i++) begin
      start(cfg(8'(ips[i]), 3'h7, 3'h0, 1'b0, 1'b1, 6'h00), b);
      t = dac.n_take;
      while (dac.n_take < t + 3) @(negedge mclk_in);
      chk("bits per sample", ips[i] + 1, dac.per_take);
    end
    $display("interpolation test done");
  endtask

  task automatic t_delay;
    int   dds[3];
    logic ref0[72];
    logic e;
    int   b;
    int   errs;
    int   ones;
    dds = '{0, 1, 63};
    ones = 0;
    for (int i = 0; i < 3; i++) begin
      start(cfg(8'h00, 3'h7, 3'h0, 1'b0, 1'b1, 6'(dds[i])), b);
      while (dac.bits.size() < b + 72) @(negedge mclk_in);
      errs = 0;
      for (int j = 0; j < 72; j++) begin
        if (i == 0) ref0[j] = dac.bits[b + j];
        if (i == 0 && ref0[j] === 1'b1) ones++;
        e = (j < dds[i]) ? 1'b0 : ref0[j - dds[i]];
        if (dac.bits[b + j] !== e) errs++;
      end
      chk("delayed bits", 32'h0, errs);
    end
    chk("stream has ones", 32'h1, ones > 0);
    $display("delay test done");
  endtask

  task automatic t_loop;
    int b;
    int l;
    int x;
    start(cfg(8'h00, 3'h7, 3'h0, 1'b0, 1'b1, 6'h00), b);
    l = dac.n_lv;
    rises(10);
    chk("loop pulses off", 32'h0, dac.n_lv - l);
    start(cfg(8'h00, 3'h7, 3'h0, 1'b1, 1'b1, 6'h00), b);
    rises(2);
    l = dac.n_lv;
    x = dac.n_ldiff;
    rises(8);
    chk("loop pulses on", 32'h8, dac.n_lv - l);
    chk("loop data", 32'h0, dac.n_ldiff - x);
    $display("loopback test done");
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rates();
    t_phase();
    t_interp();
    t_delay();
    t_loop();
    give_verdict();
  end
endmodule // tb
